// *** hw/odr_top.sv ***
// Output register tile: data and tristate paths behind an AXI4-Lite slave
`timescale 1ns/1ns
`include "odr_cfg.svh"
// How it works
// - Data and tristate paths share one clock but each has its own clock enable.
// - Each path is set on its own as flip-flop, double rate, latch or bypass.
// - Bypass sends the fabric signal straight to the driver or its enable.
// - The double rate select comes from the derived clock phase, not from a pin.
// - In split-edge mode falling edge data is taken on the divider's fall pulse, at a rising edge of that one clock.
// - Split-edge mode takes data on both edges for twice the rate.
// - Aligned-edge mode takes both inputs at the rising edge, tristate path too.
// - With the clock enable low only set, reset or a restart changes the register.
// - Reset is active high and sync or async per the timing type.
// - Set is active high and sync or async per the timing type.
// - The edge mode bit picks split or aligned, split after reset.
// - The init bit gives the output before any clocking, zero by default.
// - The timing type bit picks sync or async set and reset, sync by default.
// - Each path has its own target value, loaded on set and loaded inverted on reset.
module odr_top #(
    parameter int HALF = `ODR_HALF_DEF
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [3:0]  i_axi_awaddr,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    output logic [1:0]       o_axi_bresp,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    input  wire logic [3:0]  i_axi_araddr,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    input  wire logic        i_rise_data_in,
    input  wire logic        i_fall_data_in,
    input  wire logic        i_tri_rise_in,
    input  wire logic        i_tri_fall_in,
    input  wire logic        i_out_clk_en,
    input  wire logic        i_tristate_clk_en,
    input  wire logic        i_set_in,
    input  wire logic        i_reset_in,
    output logic             o_ddr_out,
    output logic             o_tristate_out
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`ODR_CFG_W-1:0] cfg_r, cfg_nxt;
    logic                  restart_r, restart_nxt;
    logic                  aw_got_r, aw_got_nxt;
    logic                  w_got_r, w_got_nxt;
    logic [3:0]            awaddr_r, awaddr_nxt;
    logic [31:0]           wdata_r, wdata_nxt;
    logic [3:0]            wstrb_r, wstrb_nxt;
    logic                  bvalid_r, bvalid_nxt;
    logic [1:0]            bresp_r, bresp_nxt;
    logic                  rvalid_r, rvalid_nxt;
    logic [31:0]           rdata_r, rdata_nxt;
    logic [1:0]            rresp_r, rresp_nxt;
    logic                  aw_take, w_take, do_write, ar_take;
    logic [3:0]            wa;
    logic [31:0]           wd;
    logic [3:0]            ws;
    logic                  d_st, t_st;
    odr_edge_if            edges ();

    // ----------------------------------------
    // Pad clock edges
    // ----------------------------------------
    odr_edge_gen #(
        .HALF (HALF)
    ) u_edge (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .e       (edges.src)
    );

    // ----------------------------------------
    // Data and tristate paths
    // ----------------------------------------
    // Data path with its own enable
    odr_path u_data (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .e         (edges.dst),
        .i_mode    (odr_pkg::odr_mode_t'(cfg_r[`ODR_F_DMODE])),
        .i_aligned (cfg_r[`ODR_B_EDGE]),
        .i_init    (cfg_r[`ODR_B_DINIT]),
        .i_async   (cfg_r[`ODR_B_SETRESET_TIMING_TYPE]),
        .i_setreset_target_value   (cfg_r[`ODR_B_DSRVAL]),
        .i_restart (restart_r),
        .i_ce      (i_out_clk_en),
        .i_d1      (i_rise_data_in),
        .i_d2      (i_fall_data_in),
        .i_set     (i_set_in),
        .i_reset   (i_reset_in),
        .o_q       (o_ddr_out),
        .o_started (d_st)
    );

    // Tristate path, same edge mode and timing type
    odr_path u_tri (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .e         (edges.dst),
        .i_mode    (odr_pkg::odr_mode_t'(cfg_r[`ODR_F_TMODE])),
        .i_aligned (cfg_r[`ODR_B_EDGE]),
        .i_init    (cfg_r[`ODR_B_TINIT]),
        .i_async   (cfg_r[`ODR_B_SETRESET_TIMING_TYPE]),
        .i_setreset_target_value   (cfg_r[`ODR_B_TSRVAL]),
        .i_restart (restart_r),
        .i_ce      (i_tristate_clk_en),
        .i_d1      (i_tri_rise_in),
        .i_d2      (i_tri_fall_in),
        .i_set     (i_set_in),
        .i_reset   (i_reset_in),
        .o_q       (o_tristate_out),
        .o_started (t_st)
    );

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    // Address and data taken in either order, one write at a time
    assign o_axi_awready = !aw_got_r && !bvalid_r;
    assign o_axi_wready = !w_got_r && !bvalid_r;
    assign aw_take = i_axi_awvalid && o_axi_awready;
    assign w_take = i_axi_wvalid && o_axi_wready;
    assign do_write = (aw_got_r || aw_take) && (w_got_r || w_take);
    assign wa = aw_got_r ? awaddr_r : i_axi_awaddr;
    assign wd = w_got_r ? wdata_r : i_axi_wdata;
    assign ws = w_got_r ? wstrb_r : i_axi_wstrb;
    assign o_axi_bvalid = bvalid_r;
    assign o_axi_bresp = bresp_r;

    // Write capture, register update and response
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        cfg_nxt = cfg_r;
        restart_nxt = 1'b0;
        if (aw_take) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = i_axi_awaddr;
        end
        if (w_take) begin
            w_got_nxt = 1'b1;
            wdata_nxt = i_axi_wdata;
            wstrb_nxt = i_axi_wstrb;
        end
        if (do_write) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `ODR_RESP_OK;
            if (wa == `ODR_OFF_CFG) begin
                if (ws[0]) begin
                    cfg_nxt[7:0] = wd[7:0];
                end
                if (ws[1]) begin
                    cfg_nxt[`ODR_CFG_W-1:8] = wd[`ODR_CFG_W-1:8];
                end
            end else if (wa == `ODR_OFF_CTL) begin
                restart_nxt = ws[0] && wd[`ODR_B_RESTART];
            end else if (wa == `ODR_OFF_STA) begin
                bresp_nxt = `ODR_RESP_OK;
            end else begin
                bresp_nxt = `ODR_RESP_ERR;
            end
        end else if (bvalid_r && i_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `ODR_RESP_OK;
            cfg_r <= `ODR_CFG_RST;
            restart_r <= 1'b0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            cfg_r <= cfg_nxt;
            restart_r <= restart_nxt;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    assign o_axi_arready = !rvalid_r;
    assign ar_take = i_axi_arvalid && o_axi_arready;
    assign o_axi_rvalid = rvalid_r;
    assign o_axi_rdata = rdata_r;
    assign o_axi_rresp = rresp_r;

    // Read decode, status shows live path state
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (ar_take) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `ODR_RESP_OK;
            if (i_axi_araddr == `ODR_OFF_CFG) begin
                rdata_nxt = {{(32 - `ODR_CFG_W){1'b0}}, cfg_r};
            end else if (i_axi_araddr == `ODR_OFF_CTL) begin
                rdata_nxt = 32'h0000_0000;
            end else if (i_axi_araddr == `ODR_OFF_STA) begin
                rdata_nxt = {27'h000_0000, t_st, d_st, edges.hi, o_tristate_out, o_ddr_out};
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = `ODR_RESP_ERR;
            end
        end else if (rvalid_r && i_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `ODR_RESP_OK;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    defaults_a: assert property ($fell(i_rst) |-> !cfg_r[`ODR_B_EDGE] && !cfg_r[`ODR_B_SETRESET_TIMING_TYPE]
        && !cfg_r[`ODR_B_DINIT])
        else $error("edge or timing default wrong after reset");
    tri_enable_a: assert property (cfg_r[`ODR_F_TMODE] == odr_pkg::ODR_FF && !i_tristate_clk_en
        && !i_set_in && !i_reset_in && !restart_r && !do_write && t_st
        |=> o_tristate_out == $past(o_tristate_out))
        else $error("tristate moved with its enable low");
    cover_split_c: cover property (cfg_r[`ODR_F_DMODE] == 2'h1 && !cfg_r[`ODR_B_EDGE]
        && edges.fall_en && i_out_clk_en);
    cover_aligned_c: cover property (cfg_r[`ODR_F_TMODE] == 2'h1 && cfg_r[`ODR_B_EDGE]
        && edges.fall_en && i_tristate_clk_en);
    cover_fwd_c: cover property (cfg_r[`ODR_F_DMODE] == 2'h1 && !i_rise_data_in
        && i_fall_data_in && i_out_clk_en && edges.fall_en);
endmodule

// *** hw/odr_cfg.svh ***
// Offsets, field positions and reset values of the output register block
`ifndef ODR_CFG_SVH
`define ODR_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ODR_OFF_CFG    4'h0
`define ODR_OFF_CTL    4'h4
`define ODR_OFF_STA    4'h8
// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define ODR_F_DMODE    1:0
`define ODR_F_TMODE    3:2
`define ODR_B_EDGE     4
`define ODR_B_DINIT    5
`define ODR_B_TINIT    6
`define ODR_B_SETRESET_TIMING_TYPE   7
`define ODR_B_DSRVAL   8
`define ODR_B_TSRVAL   9
`define ODR_CFG_W      10
`define ODR_CFG_RST    10'h000
`define ODR_B_RESTART  0
`define ODR_HALF_DEF   1
`define ODR_RESP_OK    2'h0
`define ODR_RESP_ERR   2'h2
`endif

// *** hw/odr_pkg.sv ***
// Types shared by the output register block
package odr_pkg;
    typedef enum logic [1:0] {
        ODR_FF,
        ODR_DDR,
        ODR_LATCH,
        ODR_COMB
    } odr_mode_t;
endpackage

// *** hw/odr_edge_if.sv ***
// Derived clock edges passed from the divider to both paths
`timescale 1ns/1ns
interface odr_edge_if;
    logic rise_en;
    logic fall_en;
    logic hi;
    modport src (output rise_en, output fall_en, output hi);
    modport dst (input rise_en, input fall_en, input hi);
endinterface

// *** hw/odr_edge_gen.sv ***
// Divider making the rising and falling edge pulses of the pad clock
`timescale 1ns/1ns
`include "odr_cfg.svh"
module odr_edge_gen #(
    parameter int HALF = `ODR_HALF_DEF
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    odr_edge_if.src   e
);
    logic [7:0] cnt_r, cnt_nxt;
    logic       hi_r, hi_nxt;
    logic       tc;
    logic       hi_n;

    // Terminal count ends each half period
    assign tc = (cnt_r == 8'(HALF - 1));
    assign hi_n = ~hi_r;
    assign e.rise_en = tc & hi_n;
    assign e.fall_en = tc & ~hi_n;
    assign e.hi = hi_r;

    // Half period counter and phase
    always_comb begin
        cnt_nxt = tc ? 8'h00 : cnt_r + 8'h01;
        hi_nxt = tc ? hi_n : hi_r;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cnt_r <= 8'h00;
            hi_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hi_r <= hi_nxt;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    rise_phase_a: assert property (e.rise_en |=> hi_r ##[0:255] e.fall_en)
        else $error("rise edge not followed by high phase and fall");
    fall_phase_a: assert property (e.fall_en |=> !hi_r && !e.fall_en)
        else $error("fall edge did not drop the phase");
endmodule

// *** hw/odr_path.sv ***
// One output path: flip-flop, double rate, latch or bypass
`timescale 1ns/1ns
module odr_path (
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    odr_edge_if.dst                e,
    input  wire odr_pkg::odr_mode_t i_mode,
    input  wire logic              i_aligned,
    input  wire logic              i_init,
    input  wire logic              i_async,
    input  wire logic              i_setreset_target_value,
    input  wire logic              i_restart,
    input  wire logic              i_ce,
    input  wire logic              i_d1,
    input  wire logic              i_d2,
    input  wire logic              i_set,
    input  wire logic              i_reset,
    output logic                   o_q,
    output logic                   o_started
);
    logic q_r, q_nxt, hold_r, hold_nxt, st_r, st_nxt;
    logic edge_any, comb;

    assign edge_any = e.rise_en | e.fall_en;
    assign comb = (i_mode == odr_pkg::ODR_COMB);
    // Bypass, init value before clocking, else register
    assign o_q = comb ? i_d1 : (st_r ? q_r : i_init);
    assign o_started = st_r;

    // Next state of the path register
    always_comb begin
        q_nxt = q_r;
        hold_nxt = hold_r;
        st_nxt = st_r;
        if (i_restart) begin
            q_nxt = i_init;
            hold_nxt = i_init;
            st_nxt = 1'b0;
        end else if ((i_set | i_reset) && (i_async || edge_any)) begin
            q_nxt = i_set ? i_setreset_target_value : ~i_setreset_target_value;
            hold_nxt = q_nxt;
            st_nxt = 1'b1;
        end else if (i_ce) begin
            case (i_mode)
                odr_pkg::ODR_FF: begin
                    if (e.rise_en) begin
                        q_nxt = i_d1;
                        st_nxt = 1'b1;
                    end
                end
                odr_pkg::ODR_DDR: begin
                    if (e.rise_en) begin
                        q_nxt = i_d1;
                        hold_nxt = i_d2;
                        st_nxt = 1'b1;
                    end else if (e.fall_en) begin
                        q_nxt = i_aligned ? hold_r : i_d2;
                        st_nxt = 1'b1;
                    end
                end
                odr_pkg::ODR_LATCH: begin
                    if (e.hi) begin
                        q_nxt = i_d1;
                        st_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            q_r <= 1'b0;
            hold_r <= 1'b0;
            st_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
            hold_r <= hold_nxt;
            st_r <= st_nxt;
        end
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic quiet;
    assign quiet = !i_set && !i_reset && !i_restart && !comb;
    comb_pass_a: assert property (comb |-> o_q == i_d1)
        else $error("bypass did not pass data");
    split_rise_a: assert property (quiet && i_ce && i_mode == odr_pkg::ODR_DDR && e.rise_en
        |=> o_q == $past(i_d1))
        else $error("rise data not shown");
    split_fall_a: assert property (quiet && i_ce && i_mode == odr_pkg::ODR_DDR && !i_aligned
        && e.fall_en |=> o_q == $past(i_d2))
        else $error("fall data not shown");
    aligned_fall_a: assert property (quiet && i_ce && i_mode == odr_pkg::ODR_DDR && i_aligned
        && e.fall_en |=> o_q == $past(hold_r))
        else $error("held fall data not shown");
    ce_hold_a: assert property (quiet && !i_ce && st_r |=> q_r == $past(q_r))
        else $error("output moved with enable low");
    async_set_a: assert property (i_async && i_set && !i_restart && !comb
        |=> o_q == $past(i_setreset_target_value))
        else $error("async set not applied");
    sync_rst_a: assert property (!i_async && i_reset && !i_set && !i_restart && !comb
        ##0 edge_any |=> o_q == !$past(i_setreset_target_value))
        else $error("sync reset not applied at edge");
    init_a: assert property (i_restart && !comb |=> o_q == $past(i_init))
        else $error("init value not shown");
endmodule

// *** sim/odr_pad_model.sv ***
// Pad driver model with a pull-up, fed by the tile's data and tristate outputs
`timescale 1ns/1ns
module odr_pad_model (
    input  wire logic i_data,
    input  wire logic i_oe_n,
    output logic      o_pad
);
    // ----------------------------------------
    // Pad level
    // ----------------------------------------
    // Driven while the enable is low, otherwise the pull-up wins
    assign o_pad = (i_oe_n === 1'b0) ? i_data : 1'b1;
endmodule

// *** sim/odr_top_tb.sv ***
// Self-checking bench for the output register tile
`timescale 1ns/1ns
`include "odr_cfg.svh"
module odr_top_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int HALF  = 1;
    localparam int LIMIT = 20000;
    logic        i_clock, i_rst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, set_in, reset_in, pad;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs, d1, d2, ce, mq, mh, hok, qok;
    wire  [1:0]  q_o;
    logic [9:0]  mcfg;
    logic        hi_m, stim_en, chk_en;
    integer      seed;
    int          n_errors, num_checks, cyc;

    odr_top #(.HALF(HALF)) u_dut (
        .i_clock(i_clock), .i_rst(i_rst),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_awaddr(awaddr),
        .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
        .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
        .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
        .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
        .i_rise_data_in(d1[0]), .i_fall_data_in(d2[0]), .i_tri_rise_in(d1[1]), .i_tri_fall_in(d2[1]),
        .i_out_clk_en(ce[0]), .i_tristate_clk_en(ce[1]), .i_set_in(set_in), .i_reset_in(reset_in),
        .o_ddr_out(q_o[0]), .o_tristate_out(q_o[1])
    );
    odr_pad_model u_pad (.i_data(q_o[0]), .i_oe_n(q_o[1]), .o_pad(pad));

    // Free-running system clock
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] md(int p);
        return p ? mcfg[3:2] : mcfg[1:0];
    endfunction

    function automatic logic exp_q(int p);
        return (md(p) == odr_pkg::ODR_COMB) ? d1[p] : mq[p];
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Write: both channels offered together, each released when taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d  = 1'b0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge i_clock);
            if (awvalid && awready) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge i_clock); while (!bvalid);
        r = bresp;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge i_clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge i_clock); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    // Quiet the fabric, load settings, restart, then resync the model
    task automatic set_cfg(input logic [9:0] c);
        stim_en <= 1'b0;
        chk_en  <= 1'b0;
        @(posedge i_clock);
        {ce, set_in, reset_in} <= '0;
        axi_wr(`ODR_OFF_CFG, {22'h0, c}, 4'hf, rs);
        axi_wr(`ODR_OFF_CTL, 32'h1, 4'hf, rs);
        mcfg = c;
        mq   = {c[6], c[5]};
        mh   = {c[6], c[5]};
        hok  = 2'b11;
        qok  = 2'b11;
        chk_en <= 1'b1;
        axi_rd(`ODR_OFF_CFG, rd, rs);
        check(rd, {22'h0, c});
        axi_rd(`ODR_OFF_STA, rd, rs);
        check({rd[4:3], rd[1:0]}, {2'b00, exp_q(1), exp_q(0)});
    endtask

    task automatic run(input int n);
        stim_en <= 1'b1;
        repeat (n) @(posedge i_clock);
    endtask

    // ----------------------------------------
    // Stimulus, model, comparison
    // ----------------------------------------
    // Random fabric inputs
    always @(posedge i_clock) begin
        if (stim_en) begin
            d1       <= 2'($random(seed));
            d2       <= 2'($random(seed));
            ce       <= 2'($random(seed));
            set_in   <= (($random(seed) & 7) == 0);
            reset_in <= (($random(seed) & 7) == 0);
        end
    end

    // Reference model of both paths and the hang limit
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc >= LIMIT) begin
            n_errors++;
            finish_test();
        end
        if (i_rst) begin
            hi_m <= 1'b0;
            mq   <= 2'b00;
            qok  <= 2'b11;
            hok  <= 2'b00;
        end else begin
            hi_m <= ~hi_m;
            for (int p = 0; p < 2; p++) begin
                if (set_in || reset_in) begin
                    mq[p]  <= set_in ? mcfg[8+p] : ~mcfg[8+p];
                    mh[p]  <= set_in ? mcfg[8+p] : ~mcfg[8+p];
                    qok[p] <= 1'b1;
                    hok[p] <= 1'b1;
                end else if (ce[p]) begin
                    if (md(p) == odr_pkg::ODR_FF && !hi_m) begin
                        mq[p] <= d1[p];
                    end else if (md(p) == odr_pkg::ODR_LATCH && hi_m) begin
                        mq[p] <= d1[p];
                    end else if (md(p) == odr_pkg::ODR_DDR && !hi_m) begin
                        mq[p]  <= d1[p];
                        mh[p]  <= d2[p];
                        hok[p] <= 1'b1;
                        qok[p] <= 1'b1;
                    end else if (md(p) == odr_pkg::ODR_DDR) begin
                        mq[p]  <= mcfg[4] ? mh[p] : d2[p];
                        qok[p] <= qok[p] & (~mcfg[4] | hok[p]);
                    end
                end
            end
        end
    end

    // Outputs against the model, mid-cycle
    always @(negedge i_clock) begin
        if (chk_en) begin
            for (int p = 0; p < 2; p++) begin
                if (qok[p]) begin
                    check(q_o[p], exp_q(p));
                end
            end
            if (&qok) begin
                check(pad, exp_q(1) ? 1'b1 : exp_q(0));
            end
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 86;
        i_rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, set_in, reset_in} = '0;
        {awaddr, araddr, wstrb, wdata, d1, d2, ce, mh} = '0;
        {stim_en, chk_en, mcfg, n_errors, num_checks, cyc} = '0;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
        // Reset values, unmapped place, byte lanes
        axi_rd(`ODR_OFF_CFG, rd, rs);
        check(rd, `ODR_CFG_RST);
        check(q_o, 2'b00);
        axi_rd(4'hc, rd, rs);
        check(rs, `ODR_RESP_ERR);
        check(rd, 32'h0);
        axi_wr(4'hc, 32'h0, 4'hf, rs);
        check(rs, `ODR_RESP_ERR);
        axi_wr(`ODR_OFF_STA, 32'hff, 4'hf, rs);
        check(rs, `ODR_RESP_OK);
        axi_wr(`ODR_OFF_CFG, 32'h3ff, 4'h1, rs);
        axi_rd(`ODR_OFF_CFG, rd, rs);
        check(rd, 32'h0ff);
        $display("test regs done");
        // Every mode pair, random edge, init, timing and target bits
        for (int i = 0; i < 16; i++) begin
            set_cfg({6'($random(seed)), 4'(i)});
            run(48);
        end
        $display("test modes done");
        // Clock forwarding on the data path in split-edge mode
        set_cfg(10'h001);
        d1 <= 2'b00;
        d2 <= 2'b01;
        ce <= 2'b11;
        repeat (16) @(posedge i_clock);
        $display("test forward done");
        // Fully random settings
        for (int i = 0; i < 16; i++) begin
            set_cfg(10'($random(seed)));
            run(48);
        end
        $display("test random done");
        finish_test();
    end
endmodule
